// >>> crsfi_regset.sv
// CPU register set with fast interrupt backup and wide DSP sum
// Functional notes
// [RULE_01] Sixteen general registers; one to fifteen serve as data or address.
// [RULE_02] Register zero is the stack pointer storage.
// [RULE_03] Status stack select bit picks interrupt or user stack pointer.
// [RULE_04] Software should keep stack pointers multiples of four.
// [RULE_05] Vector base holds table start; lookups are relative to it.
// [RULE_06] Instruction pointer holds the executing instruction address.
// [RULE_07] Fast interrupt saves instruction pointer into backup counter.
// [RULE_08] Fast interrupt saves status word into same-layout backup.
// [RULE_09] Fast interrupt branches to fast vector target register.
// [RULE_10] A 64-bit wide sum register serves DSP instructions.
// [RULE_11] Multiply-class instructions overwrite the wide sum.
// [RULE_12] High write loads bits 63..32, low write loads bits 31..0.
// [RULE_13] High read returns 63..32, middle read returns 47..16.
// [RULE_14] Addresses are one linear 32-bit space for program and data.
// [RULE_15] I/O stores are posted; next instruction proceeds at once.
// [RULE_16] I/O read waits until every earlier posted write completes. The counter stops at 15 outstanding; a write beyond that is not waited for.
// [RULE_17] All general, counter, status and backup registers are 32 bits.
`include "crsfi_defs.svh"
module crsfi_regset (
  // Clock and reset
  input  wire logic                    CLK_SYS_I,
  input  wire logic                    RST_I,
  // General register port
  input  wire logic [3:0]              RD_IDX_A_I,
  input  wire logic [3:0]              RD_IDX_B_I,
  input  wire logic                    WR_EN_I,
  input  wire logic [3:0]              WR_IDX_I,
  input  wire crsfi_pkg::crsfi_word_t  WR_DATA_I,
  output crsfi_pkg::crsfi_word_t       RD_DATA_A_O,
  output crsfi_pkg::crsfi_word_t       RD_DATA_B_O,
  // Control registers
  input  wire logic                    PC_LOAD_I,
  input  wire crsfi_pkg::crsfi_word_t  PC_NEXT_I,
  input  wire logic                    PSW_WR_I,
  input  wire crsfi_pkg::crsfi_word_t  PSW_DATA_I,
  input  wire logic                    VTB_WR_I,
  input  wire logic                    FVT_WR_I,
  input  wire crsfi_pkg::crsfi_word_t  CTRL_DATA_I,
  input  wire logic [7:0]              VEC_NUM_I,
  output crsfi_pkg::crsfi_word_t       PC_O,
  output crsfi_pkg::crsfi_word_t       PSW_O,
  output crsfi_pkg::crsfi_word_t       SAVED_PC_O,
  output crsfi_pkg::crsfi_word_t       SAVED_PSW_O,
  output crsfi_pkg::crsfi_word_t       VEC_ADDR_O,
  // Fast interrupt
  input  wire logic                    FAST_IRQ_I,
  // Wide sum
  input  wire crsfi_pkg::crsfi_acc_op_t ACC_OP_I,
  input  wire crsfi_pkg::crsfi_word_t  ACC_DATA_I,
  input  wire crsfi_pkg::crsfi_wide_t  ACC_PROD_I,
  output crsfi_pkg::crsfi_word_t       ACC_HI_O,
  output crsfi_pkg::crsfi_word_t       ACC_MID_O,
  // I/O write posting
  input  wire logic                    IO_WR_I,
  input  wire logic                    IO_WR_DONE_I,
  input  wire logic                    IO_RD_I,
  output logic                         IO_RD_GO_O,
  output logic                         IO_FULL_O
);
  // General registers; entry zero is never read, the stack pointers stand in
  crsfi_pkg::crsfi_word_t gr_q [`CRSFI_NREGS];
  crsfi_pkg::crsfi_word_t gr_d [`CRSFI_NREGS];
  // Banked stack pointers
  crsfi_pkg::crsfi_word_t istk_q;
  crsfi_pkg::crsfi_word_t istk_d;
  crsfi_pkg::crsfi_word_t ustk_q;
  crsfi_pkg::crsfi_word_t ustk_d;
  // Instruction pointer and status word
  crsfi_pkg::crsfi_word_t ip_q;
  crsfi_pkg::crsfi_word_t ip_d;
  crsfi_pkg::crsfi_word_t stat_q;
  crsfi_pkg::crsfi_word_t stat_d;
  // Fast interrupt backup copies
  crsfi_pkg::crsfi_word_t svip_q;
  crsfi_pkg::crsfi_word_t svip_d;
  crsfi_pkg::crsfi_word_t svst_q;
  crsfi_pkg::crsfi_word_t svst_d;
  // Vector table base and fast vector target
  crsfi_pkg::crsfi_word_t vtb_q;
  crsfi_pkg::crsfi_word_t vtb_d;
  crsfi_pkg::crsfi_word_t fvt_q;
  crsfi_pkg::crsfi_word_t fvt_d;
  // Registered read data and vector address
  crsfi_pkg::crsfi_word_t ra_q;
  crsfi_pkg::crsfi_word_t ra_d;
  crsfi_pkg::crsfi_word_t rb_q;
  crsfi_pkg::crsfi_word_t rb_d;
  crsfi_pkg::crsfi_word_t va_q;
  crsfi_pkg::crsfi_word_t va_d;
  // Wide sum
  crsfi_pkg::crsfi_wide_t wsum_q;
  crsfi_pkg::crsfi_wide_t wsum_d;
  // Posting tracker status
  logic                   io_full;
  logic                   io_go;
  logic                   full_q;

  // Stack select decode; high picks the user copy
  function automatic logic stk_user(input crsfi_pkg::crsfi_word_t stat);
    return stat[`CRSFI_STK_SEL_BIT]; // [RULE_03]
  endfunction : stk_user

  // Register read with stack pointer aliasing
  function automatic crsfi_pkg::crsfi_word_t rd_sel(input logic [3:0] idx,
      input crsfi_pkg::crsfi_word_t stk_val);
    crsfi_pkg::crsfi_word_t r;
    r = (idx == 4'h0) ? stk_val : gr_q[idx]; // [RULE_02]
    return r;
  endfunction : rd_sel

  // Next state of register set
  always_comb begin
    crsfi_pkg::crsfi_word_t stk_now;
    stk_now = stk_user(stat_q) ? ustk_q : istk_q; // [RULE_03]
    for (int i = 0; i < `CRSFI_NREGS; i++) begin
      gr_d[i] = gr_q[i];
    end
    istk_d = istk_q;
    ustk_d = ustk_q;
    ip_d   = ip_q;
    stat_d = stat_q;
    svip_d = svip_q;
    svst_d = svst_q;
    vtb_d  = vtb_q;
    fvt_d  = fvt_q;
    wsum_d = wsum_q;
    // General writes; index zero lands in the active stack pointer
    if (WR_EN_I) begin
      if (WR_IDX_I == 4'h0) begin
        if (stk_user(stat_q)) begin
          ustk_d = WR_DATA_I; // [RULE_03]
        end else begin
          istk_d = WR_DATA_I; // [RULE_02]
        end
      end else begin
        gr_d[WR_IDX_I] = WR_DATA_I; // [RULE_01]
      end
    end
    if (PSW_WR_I) stat_d = PSW_DATA_I;
    if (VTB_WR_I) vtb_d = CTRL_DATA_I; // [RULE_05]
    if (FVT_WR_I) fvt_d = CTRL_DATA_I;
    if (PC_LOAD_I) ip_d = PC_NEXT_I; // [RULE_06]
    // Fast interrupt save and branch; wins over a same-cycle load
    if (FAST_IRQ_I) begin
      svip_d = ip_q; // [RULE_07]
      svst_d = stat_q; // [RULE_08]
      ip_d   = fvt_q; // [RULE_09]
    end
    // Wide sum updates
    case (ACC_OP_I)
      crsfi_pkg::CRSFI_ACC_NONE: wsum_d = wsum_q;
      crsfi_pkg::CRSFI_ACC_WHI:  wsum_d = {ACC_DATA_I, wsum_q[31:0]}; // [RULE_12]
      crsfi_pkg::CRSFI_ACC_WLO:  wsum_d = {wsum_q[63:32], ACC_DATA_I}; // [RULE_12]
      crsfi_pkg::CRSFI_ACC_PROD: wsum_d = ACC_PROD_I; // [RULE_11]
      default:                   wsum_d = wsum_q;
    endcase
    ra_d = rd_sel(RD_IDX_A_I, stk_now); // [RULE_01]
    rb_d = rd_sel(RD_IDX_B_I, stk_now);
    // Table base plus four bytes per vector, wrapping in 32 bits
    va_d = 32'(vtb_q + {22'h0, VEC_NUM_I, 2'h0}); // [RULE_14]
  end

  // Register everything
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      for (int i = 0; i < `CRSFI_NREGS; i++) begin
        gr_q[i] <= `CRSFI_RESET_WORD; // [RULE_17]
      end
      istk_q <= `CRSFI_RESET_WORD;
      ustk_q <= `CRSFI_RESET_WORD;
      ip_q   <= `CRSFI_RESET_WORD;
      stat_q <= `CRSFI_RESET_WORD;
      svip_q <= `CRSFI_RESET_WORD;
      svst_q <= `CRSFI_RESET_WORD;
      vtb_q  <= `CRSFI_RESET_WORD;
      fvt_q  <= `CRSFI_RESET_WORD;
      wsum_q <= 64'h0;
      ra_q   <= `CRSFI_RESET_WORD;
      rb_q   <= `CRSFI_RESET_WORD;
      va_q   <= `CRSFI_RESET_WORD;
      full_q <= 1'b0;
    end else begin
      for (int i = 0; i < `CRSFI_NREGS; i++) begin
        gr_q[i] <= gr_d[i];
      end
      istk_q <= istk_d;
      ustk_q <= ustk_d;
      ip_q   <= ip_d;
      stat_q <= stat_d;
      svip_q <= svip_d;
      svst_q <= svst_d;
      vtb_q  <= vtb_d;
      fvt_q  <= fvt_d;
      wsum_q <= wsum_d; // [RULE_10]
      ra_q   <= ra_d;
      rb_q   <= rb_d;
      va_q   <= va_d;
      full_q <= io_full;
    end
  end

  // Posted I/O write tracking; writes never stall the core
  crsfi_post_track u_post (
    .clk_i      (CLK_SYS_I),
    .rst_i      (RST_I),
    .wr_post_i  (IO_WR_I), // [RULE_15]
    .wr_done_i  (IO_WR_DONE_I),
    .rd_req_i   (IO_RD_I),
    .full_o     (io_full),
    .rd_grant_o (io_go)
  );

  // Outputs from flip-flops
  assign RD_DATA_A_O = ra_q;
  assign RD_DATA_B_O = rb_q;
  assign PC_O        = ip_q;
  assign PSW_O       = stat_q;
  assign SAVED_PC_O  = svip_q;
  assign SAVED_PSW_O = svst_q;
  assign VEC_ADDR_O  = va_q; // [RULE_05]
  assign ACC_HI_O    = wsum_q[63:32]; // [RULE_13]
  assign ACC_MID_O   = wsum_q[47:16]; // [RULE_13]
  assign IO_RD_GO_O  = io_go; // [RULE_16]
  assign IO_FULL_O   = full_q;
endmodule : crsfi_regset

// >>> crsfi_defs.svh
// Constants for the CPU register set block
`ifndef CRSFI_DEFS_SVH
`define CRSFI_DEFS_SVH
`define CRSFI_NREGS        16
`define CRSFI_RIDX_W       4
`define CRSFI_STK_SEL_BIT  17
`define CRSFI_RESET_WORD   32'h0000_0000
`define CRSFI_ADDR_MAX     32'hFFFF_FFFF
`define CRSFI_POST_CNT_W   4
`define CRSFI_POST_MAX     4'hF
`endif

// >>> crsfi_pkg.sv
// Types for the CPU register set block
package crsfi_pkg;
  typedef logic [31:0] crsfi_word_t;
  typedef logic [63:0] crsfi_wide_t;
  typedef enum logic [3:0] {
    CRSFI_ACC_NONE  = 4'h1,
    CRSFI_ACC_WHI   = 4'h2,
    CRSFI_ACC_WLO   = 4'h4,
    CRSFI_ACC_PROD  = 4'h8
  } crsfi_acc_op_t;
endpackage : crsfi_pkg

// >>> crsfi_post_track.sv
// Posted I/O write tracker giving a read completion barrier
`include "crsfi_defs.svh"
module crsfi_post_track (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Traffic
  input  wire logic wr_post_i,
  input  wire logic wr_done_i,
  input  wire logic rd_req_i,
  // Status
  output logic      full_o,
  output logic      rd_grant_o
);
  logic [`CRSFI_POST_CNT_W-1:0] cnt_q;
  logic [`CRSFI_POST_CNT_W-1:0] cnt_d;
  logic                         gnt_q;
  logic                         gnt_d;

  // Outstanding posted writes
  always_comb begin
    cnt_d = cnt_q;
    if (wr_post_i && !wr_done_i && cnt_q != `CRSFI_POST_MAX) begin
      cnt_d = cnt_q + 4'h1;
    end else if (!wr_post_i && wr_done_i && cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end
    gnt_d = rd_req_i && (cnt_d == 4'h0) && !wr_post_i; // [RULE_16]
  end

  // Register state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      gnt_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      gnt_q <= gnt_d;
    end
  end

  assign full_o     = (cnt_q == `CRSFI_POST_MAX);
  assign rd_grant_o = gnt_q;
endmodule : crsfi_post_track

// >>> crsfi_regset_props.sv
// Port assertions for the CPU register set
module crsfi_regset_props (
  // Controls and status
  input wire logic CLK_SYS_I, RST_I, FAST_IRQ_I, PC_LOAD_I, IO_WR_I, IO_WR_DONE_I, IO_RD_GO_O,
  // Words
  input wire crsfi_pkg::crsfi_word_t PC_NEXT_I, ACC_DATA_I, PC_O, PSW_O, SAVED_PC_O,
  input wire crsfi_pkg::crsfi_word_t SAVED_PSW_O, ACC_HI_O, ACC_MID_O,
  input wire crsfi_pkg::crsfi_wide_t ACC_PROD_I,
  input wire crsfi_pkg::crsfi_acc_op_t ACC_OP_I
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // Fast interrupt save and counter load
  sequence s_fast; FAST_IRQ_I; endsequence
  property p_fpc; s_fast |=> SAVED_PC_O == $past(PC_O); endproperty
  a_fpc: assert property (p_fpc) else $error("saved pc wrong");
  property p_fpsw; s_fast |=> SAVED_PSW_O == $past(PSW_O); endproperty
  a_fpsw: assert property (p_fpsw) else $error("saved status wrong");
  property p_pc; PC_LOAD_I && !FAST_IRQ_I |=> PC_O == $past(PC_NEXT_I); endproperty
  a_pc: assert property (p_pc) else $error("pc load wrong");
  // Wide sum halves and product load
  property p_whi; ACC_OP_I == crsfi_pkg::CRSFI_ACC_WHI |=> ACC_HI_O == $past(ACC_DATA_I)
    && ACC_MID_O[31:16] == 16'($past(ACC_DATA_I)); endproperty
  a_whi: assert property (p_whi) else $error("high write wrong");
  property p_wlo; ACC_OP_I == crsfi_pkg::CRSFI_ACC_WLO |=> $stable(ACC_HI_O)
    && ACC_MID_O[15:0] == $past(ACC_DATA_I) >> 16; endproperty
  a_wlo: assert property (p_wlo) else $error("low write wrong");
  property p_prod; ACC_OP_I == crsfi_pkg::CRSFI_ACC_PROD
    |=> {ACC_HI_O, ACC_MID_O[15:0]} == $past(ACC_PROD_I) >> 16; endproperty
  a_prod: assert property (p_prod) else $error("product load wrong");
  // Read grant held back by posted writes
  sequence s_pend; IO_WR_I ##1 !IO_WR_DONE_I; endsequence
  property p_iow; IO_WR_I |=> !IO_RD_GO_O; endproperty
  a_iow: assert property (p_iow) else $error("grant beside new write");
  property p_pend; s_pend |=> !IO_RD_GO_O; endproperty
  a_pend: assert property (p_pend) else $error("grant while pending");
endmodule : crsfi_regset_props
bind crsfi_regset crsfi_regset_props u_props (.*);

// >>> crsfi_io_model.sv
// Peripheral side that completes posted writes
module crsfi_io_model (
  // Clock, write issue, latency
  input  wire logic       clk_i,
  input  wire logic       wr_i,
  input  wire logic [3:0] lat_i,
  // Completion pulse
  output logic            done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] pipe_q = '0;
  // Completes each write in issue order lat_i plus one cycles after it is issued
  always @(posedge clk_i) pipe_q <= {pipe_q[14:0], wr_i};
  assign done_o = pipe_q[lat_i];
endmodule : crsfi_io_model

// >>> tb_crsfi_regset.sv
// Self-checking bench for the CPU register set
module tb_crsfi_regset;
  timeunit 1ns;
  timeprecision 1ns;
  // Starts low so the first wait sees no edge at time zero
  logic clk = 1'b0;
  logic rst, wen, pcl, pswr, vtbw, fvtw, irq, iowr, iord, iodn, go, full;
  logic [3:0] ra, rb, wi, lat;
  logic [7:0] vn;
  crsfi_pkg::crsfi_word_t wd, pcn, pswd, cd, accd, rda, rdb, pc, processor_status_word, spc, spsw, va, ahi, amid;
  crsfi_pkg::crsfi_wide_t prod;
  crsfi_pkg::crsfi_acc_op_t op;
  int err_count, num_checks;
  crsfi_regset dut (.CLK_SYS_I(clk), .RST_I(rst), .RD_IDX_A_I(ra), .RD_IDX_B_I(rb),
    .WR_EN_I(wen), .WR_IDX_I(wi), .WR_DATA_I(wd), .RD_DATA_A_O(rda), .RD_DATA_B_O(rdb),
    .PC_LOAD_I(pcl), .PC_NEXT_I(pcn), .PSW_WR_I(pswr), .PSW_DATA_I(pswd), .VTB_WR_I(vtbw),
    .FVT_WR_I(fvtw), .CTRL_DATA_I(cd), .VEC_NUM_I(vn), .PC_O(pc), .PSW_O(processor_status_word),
    .SAVED_PC_O(spc), .SAVED_PSW_O(spsw), .VEC_ADDR_O(va), .FAST_IRQ_I(irq), .ACC_OP_I(op),
    .ACC_DATA_I(accd), .ACC_PROD_I(prod), .ACC_HI_O(ahi), .ACC_MID_O(amid), .IO_WR_I(iowr),
    .IO_WR_DONE_I(iodn), .IO_RD_I(iord), .IO_RD_GO_O(go), .IO_FULL_O(full));
  crsfi_io_model peri (.clk_i(clk), .wr_i(iowr), .lat_i(lat), .done_o(iodn));
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic cyc(input int n = 1);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input string n, input crsfi_pkg::crsfi_word_t e, g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] i, input crsfi_pkg::crsfi_word_t d);
    {wen, wi, wd} = {1'b1, i, d};
    cyc();
    wen = 1'b0;
    cyc();
  endtask : wr
  task automatic setpsw(input crsfi_pkg::crsfi_word_t d);
    {pswr, pswd} = {1'b1, d};
    cyc();
    pswr = 1'b0;
    cyc();
  endtask : setpsw
  // General registers and banked stack pointer
  task automatic t_gpr;
    for (int i = 1; i < 16; i++) wr(4'(i), 32'hA500_0000 + 32'(i));
    wr(4'h0, 32'h0000_1000);
    setpsw(32'h0002_0000);
    wr(4'h0, 32'h0000_2000);
    chk("psw", 32'h0002_0000, processor_status_word);
    for (int i = 1; i < 16; i++) begin
      rb = 4'(i);
      cyc();
      chk("gpr", 32'hA500_0000 + 32'(i), rdb);
    end
    chk("usp", 32'h0000_2000, rda);
    setpsw(32'h0000_0000);
    cyc();
    chk("isp", 32'h0000_1000, rda);
  endtask : t_gpr
  // Vector base, fast entry, wide sum
  task automatic t_ctl;
    {vtbw, cd, vn} = {1'b1, 32'hFFFF_FC00, 8'hFF};
    cyc();
    {vtbw, pcl, pcn} = {1'b0, 1'b1, 32'h0000_4000};
    cyc();
    chk("vec", 32'hFFFF_FFFC, va);
    chk("pc", 32'h0000_4000, pc);
    {pcl, fvtw, cd} = {1'b0, 1'b1, 32'h0000_8000};
    setpsw(32'h0002_0005);
    {fvtw, pcl, irq, pcn} = {1'b0, 1'b1, 1'b1, 32'h1234_5678};
    cyc();
    {pcl, irq} = 2'b00;
    chk("fpc", 32'h0000_8000, pc);
    chk("spc", 32'h0000_4000, spc);
    chk("spsw", 32'h0002_0005, spsw);
    chk("acc", 32'h0, ahi);
    op = crsfi_pkg::CRSFI_ACC_WHI;
    accd = 32'h89AB_CDEF;
    cyc();
    op = crsfi_pkg::CRSFI_ACC_WLO;
    accd = 32'h0123_4567;
    cyc();
    chk("hi", 32'h89AB_CDEF, ahi);
    op = crsfi_pkg::CRSFI_ACC_PROD;
    prod = 64'hFEDC_BA98_7654_3210;
    chk("mid", 32'hCDEF_0123, amid);
    cyc();
    op = crsfi_pkg::CRSFI_ACC_NONE;
    chk("prod", 32'hBA98_7654, amid);
  endtask : t_ctl
  // Posted writes then a barrier read; grant one cycle after the last completion
  task automatic t_io(input logic [3:0] l, input int k);
    int n;
    logic seen;
    {lat, iowr} = {l, 1'b1};
    cyc(k);
    iowr = 1'b0;
    iord = 1'b1;
    n = 0;
    seen = 1'b0;
    while (go !== 1'b1 && n < 40) begin
      cyc();
      n++;
      seen = seen | (full === 1'b1);
    end
    iord = 1'b0;
    chk("wait", 32'(l) + 32'h1, 32'(n));
    chk("full seen", 32'(k == 15), {31'h0, seen});
    chk("full", 32'h0, {31'h0, full});
    // Drain the far side history before the latency changes
    cyc(16);
  endtask : t_io
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // Watchdog
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
  // Main sequence
  initial begin
    {wen, pcl, pswr, vtbw, fvtw, irq, iowr, iord, ra, rb, wi, lat, vn} = '0;
    {wd, pcn, pswd, cd, accd, prod, err_count, num_checks} = '0;
    rst = 1'b1;
    op = crsfi_pkg::CRSFI_ACC_NONE;
    cyc(5);
    rst = 1'b0;
    t_gpr();
    t_ctl();
    t_io(4'h0, 2);
    t_io(4'h4, 2);
    t_io(4'hF, 15);
    stop_test();
  end
endmodule : tb_crsfi_regset
